// ===== src/four_mode_serial_port.sv
// Full-duplex serial port: shift register mode and three UART modes, with a
// receive holding buffer. Assumes the core reaches it over a byte-wide special
// register port, and that timer overflows arrive as single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Receive buffer holds byte while next frame shifts.
// - Buffer write loads transmit; read gives receive.
// - Two select bits pick one of four modes.
// - 8-bit multiproc mode needs valid stop bit.
// - 9-bit multiproc mode needs ninth bit one.
// - Receive starts only while receive enable is set.
// - Ninth transmitted bit comes from control field.
// - Receive ninth field holds ninth or stop.
// - Transmit done set at bit eight/stop start.
// - Receive done set at bit eight/mid stop.
// - Shift mode: data on rxd, clock on txd.
// - Shift receive starts when enabled and flag clear.
// - Shift mode bit rate is core clock/12.
// - 8-bit frame: start, eight data LSB first, stop.
// - 8-bit write loads stop into ninth position.
// - UART receive starts on falling line edge.
// - Accept frame only if flag clear, stop one.
// - 9-bit frame eleven bits; fixed rate /32 or /16.
// - 9-bit transmit loads byte plus ninth, waits tick.
// - Variable 9-bit mode uses timer overflow rate.
// - Variable modes use timer one or two overflows.
// - Any buffer write starts transmit in every mode.
// - Separate select bits pick timer per direction.
module four_mode_serial_port (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic rate_double_i,
  input wire logic rx_clock_select_i,
  input wire logic tx_clock_select_i,
  input wire logic timer1_overflow_i,
  input wire logic timer2_overflow_i,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_o,
  output logic txd_o
);
  import serial_pkg::*;

  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_SHIFT = 2'b11,
                            TX_STOP = 2'b10} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11,
                            RX_STOP = 2'b10} rx_state_t;
  typedef enum logic [1:0] {M0_IDLE = 2'b00, M0_TX = 2'b01, M0_RX = 2'b11} shift_state_t;

  serial_mode_t mode;
  logic multiproc_enable, rx_enable, transmit_ninth_bit, receive_ninth_bit;
  logic transmit_done_flag, receive_done_flag;
  logic [7:0] rx_buffer, next_rx_byte, m0_shift;
  logic wr_control, wr_data, uart_mode, nine_bit, fixed_rate;
  logic tx_done_set, rx_load, rx_done_set, next_rx_ninth;
  logic tx_strobe, rx_strobe, tx_os_tick, rx_os_tick, tx_bit_tick;
  logic [4:0] tx_prescale, rx_prescale;
  tx_state_t tx_state;
  rx_state_t rx_state;
  logic [8:0] tx_shift, rx_shift;
  logic [3:0] tx_count, rx_count, m0_phase;
  logic rxd_prev, rx_start_edge, rx_bit_valid, rx_bit_value, uart_ninth, uart_accept, uart_txd;
  shift_state_t m0_state;
  logic [2:0] m0_bits;
  logic m0_clock, m0_out, m0_period_end, m0_done;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port decode and mode flags
  assign wr_control = sfr_wr_i && (sfr_addr_i == CONTROL_STATUS_ADDR);
  assign wr_data = sfr_wr_i && (sfr_addr_i == DATA_BUFFER_ADDR);
  assign uart_mode = (mode != MODE_SHIFT);
  assign nine_bit = mode[1];
  assign fixed_rate = (mode == MODE_UART9_FIXED);

  // Control fields; hardware sets beat a software clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mode <= serial_mode_t'(CONTROL_STATUS_RESET[MODE_SELECT_HI_BIT:MODE_SELECT_LO_BIT]);
      multiproc_enable <= CONTROL_STATUS_RESET[MULTIPROC_ENABLE_BIT];
      rx_enable <= CONTROL_STATUS_RESET[RX_ENABLE_BIT];
      transmit_ninth_bit <= CONTROL_STATUS_RESET[TRANSMIT_NINTH_BIT];
      transmit_done_flag <= CONTROL_STATUS_RESET[TRANSMIT_DONE_BIT];
      receive_done_flag <= CONTROL_STATUS_RESET[RECEIVE_DONE_BIT];
    end else begin
      if (wr_control) begin
        mode <= serial_mode_t'(sfr_wdata_i[MODE_SELECT_HI_BIT:MODE_SELECT_LO_BIT]);
        multiproc_enable <= sfr_wdata_i[MULTIPROC_ENABLE_BIT];
        rx_enable <= sfr_wdata_i[RX_ENABLE_BIT];
        transmit_ninth_bit <= sfr_wdata_i[TRANSMIT_NINTH_BIT];
      end
      transmit_done_flag <= tx_done_set ||
        (wr_control ? sfr_wdata_i[TRANSMIT_DONE_BIT] : transmit_done_flag);
      receive_done_flag <= rx_done_set ||
        (wr_control ? sfr_wdata_i[RECEIVE_DONE_BIT] : receive_done_flag);
    end
  end

  // Receive ninth field: frame capture wins over a software write
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      receive_ninth_bit <= CONTROL_STATUS_RESET[RECEIVE_NINTH_BIT];
    end else if (rx_load && uart_mode) begin
      receive_ninth_bit <= next_rx_ninth;
    end else if (wr_control) begin
      receive_ninth_bit <= sfr_wdata_i[RECEIVE_NINTH_BIT];
    end
  end

  // Receive holding register, separate from all three shift registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx_buffer <= DATA_BUFFER_RESET;
    end else if (rx_load) begin
      rx_buffer <= next_rx_byte;
    end
  end

  // Registered read data; unmapped addresses read as zero
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sfr_rdata_o <= UNMAPPED_READ;
    end else if (sfr_rd_i) begin
      if (sfr_addr_i == CONTROL_STATUS_ADDR) begin
        sfr_rdata_o <= {mode, multiproc_enable, rx_enable, transmit_ninth_bit,
                        receive_ninth_bit, transmit_done_flag, receive_done_flag};
      end else if (sfr_addr_i == DATA_BUFFER_ADDR) begin
        sfr_rdata_o <= rx_buffer;
      end else begin
        sfr_rdata_o <= UNMAPPED_READ;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Rate strobes: fixed mode counts core clocks, variable modes count overflows
  assign tx_strobe = fixed_rate ? 1'b1 :
                     (tx_clock_select_i ? timer2_overflow_i : timer1_overflow_i);
  assign rx_strobe = fixed_rate ? 1'b1 :
                     (rx_clock_select_i ? timer2_overflow_i : timer1_overflow_i);
  // Timer two already runs at sixteen overflows per bit; the others halve unless doubled
  assign tx_prescale = (!fixed_rate && tx_clock_select_i) ? TIMER2_PRESCALE :
                       (rate_double_i ? PRESCALE_DOUBLE : PRESCALE_NORMAL);
  assign rx_prescale = (!fixed_rate && rx_clock_select_i) ? TIMER2_PRESCALE :
                       (rate_double_i ? PRESCALE_DOUBLE : PRESCALE_NORMAL);

  // Oversample and bit ticks derived from single-cycle strobes
  strobe_divider tx_prescaler (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clear_i(wr_control),
    .strobe_i(tx_strobe), .divide_i(tx_prescale), .tick_o(tx_os_tick));
  strobe_divider rx_prescaler (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clear_i(wr_control),
    .strobe_i(rx_strobe), .divide_i(rx_prescale), .tick_o(rx_os_tick));
  strobe_divider tx_bit_divider (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clear_i(wr_control),
    .strobe_i(tx_os_tick), .divide_i(OVERSAMPLE), .tick_o(tx_bit_tick));

  ////////////////////////////////////////////////////////////////////////////////
  // UART transmitter; a write during a frame restarts it with the new byte
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_state <= TX_IDLE;
      tx_shift <= 9'h1FF;
      tx_count <= 4'h0;
      uart_txd <= 1'b1;
    end else if (!uart_mode) begin
      tx_state <= TX_IDLE;
      uart_txd <= 1'b1;
    end else if (wr_data) begin
      // Ninth position: stop bit in 8-bit mode, control field in 9-bit modes
      tx_shift <= {nine_bit ? transmit_ninth_bit : 1'b1, sfr_wdata_i};
      tx_state <= TX_WAIT;
      uart_txd <= 1'b1;
    end else if (tx_bit_tick) begin
      case (tx_state)
        TX_WAIT: begin
          uart_txd <= 1'b0;
          tx_count <= nine_bit ? DATA_BITS_9 : DATA_BITS_8;
          tx_state <= TX_SHIFT;
        end
        TX_SHIFT: begin
          if (tx_count == 4'h0) begin
            uart_txd <= 1'b1;
            tx_state <= TX_STOP;
          end else begin
            uart_txd <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[8:1]};
            tx_count <= tx_count - 4'h1;
          end
        end
        TX_STOP: begin
          tx_state <= TX_IDLE;
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // UART receiver; frames that start while receive enable is low are ignored
  assign rx_start_edge = uart_mode && rx_enable && (rx_state == RX_IDLE) &&
                         rxd_prev && !rxd_i;

  bit_sampler rx_sampler (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .restart_i(rx_start_edge),
    .os_tick_i(rx_os_tick), .line_i(rxd_i), .bit_valid_o(rx_bit_valid),
    .bit_value_o(rx_bit_value));

  // Buffer load happens at mid stop bit; ninth field is the stop bit in 8-bit mode
  assign uart_ninth = nine_bit ? rx_shift[8] : rx_bit_value;
  assign uart_accept = (rx_state == RX_STOP) && rx_bit_valid && !receive_done_flag &&
                       rx_bit_value && (!multiproc_enable || uart_ninth);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rxd_prev <= 1'b1;
    end else begin
      rxd_prev <= rxd_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx_state <= RX_IDLE;
      rx_shift <= 9'h000;
      rx_count <= 4'h0;
    end else if (!uart_mode || !rx_enable) begin
      rx_state <= RX_IDLE;
    end else if (rx_start_edge) begin
      rx_state <= RX_START;
    end else if (rx_bit_valid) begin
      case (rx_state)
        RX_START: begin
          // A start bit that reads high at its centre was noise
          rx_state <= rx_bit_value ? RX_IDLE : RX_DATA;
          rx_count <= nine_bit ? DATA_BITS_9 : DATA_BITS_8;
        end
        RX_DATA: begin
          rx_shift <= {rx_bit_value, rx_shift[8:1]};
          rx_count <= rx_count - 4'h1;
          if (rx_count == 4'h1) begin
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          rx_state <= RX_IDLE;
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shift register mode: one engine, as both directions share the data pin
  assign m0_period_end = (m0_phase == SHIFT_DIVIDE - 4'h1);
  assign m0_done = (m0_state != M0_IDLE) && m0_period_end && (m0_bits == SHIFT_LAST_BIT);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      m0_state <= M0_IDLE;
      m0_phase <= 4'h0;
      m0_bits <= 3'h0;
      m0_shift <= 8'h00;
      m0_clock <= 1'b1;
      m0_out <= 1'b1;
    end else if (uart_mode) begin
      m0_state <= M0_IDLE;
      m0_clock <= 1'b1;
    end else if (wr_data) begin
      // Transmit has priority; it aborts a reception in progress
      m0_state <= M0_TX;
      m0_shift <= sfr_wdata_i;
      m0_out <= sfr_wdata_i[0];
      m0_phase <= 4'h0;
      m0_bits <= 3'h0;
      m0_clock <= 1'b0;
    end else if (m0_state == M0_IDLE) begin
      if (rx_enable && !receive_done_flag) begin
        m0_state <= M0_RX;
        m0_phase <= 4'h0;
        m0_bits <= 3'h0;
        m0_clock <= 1'b0;
      end
    end else begin
      m0_phase <= m0_period_end ? 4'h0 : m0_phase + 4'h1;
      if (m0_phase == SHIFT_HALF - 4'h1) begin
        m0_clock <= 1'b1;
        if (m0_state == M0_RX) begin
          m0_shift <= {rxd_i, m0_shift[7:1]};
        end
      end
      if (m0_period_end) begin
        m0_bits <= m0_bits + 3'h1;
        if (m0_done) begin
          m0_state <= M0_IDLE;
          m0_clock <= 1'b1;
        end else begin
          m0_clock <= 1'b0;
          if (m0_state == M0_TX) begin
            m0_out <= m0_shift[1];
            m0_shift <= {1'b0, m0_shift[7:1]};
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flag sources and receive buffer load
  assign tx_done_set = (uart_mode && tx_state == TX_SHIFT && tx_bit_tick && !wr_data &&
                        tx_count == 4'h0) || (m0_done && m0_state == M0_TX);
  assign rx_load = uart_accept || (m0_done && m0_state == M0_RX);
  assign rx_done_set = rx_load;
  assign next_rx_byte = !uart_mode ? m0_shift : (nine_bit ? rx_shift[7:0] : rx_shift[8:1]);
  assign next_rx_ninth = uart_ninth;

  // Pins: data drives rxd only while shifting out; txd carries clock or frame
  assign rxd_o = m0_out;
  assign rxd_oe_o = (m0_state == M0_TX);
  assign txd_o = uart_mode ? uart_txd : m0_clock;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_tx_done_timing: assert property (tx_done_set |=> transmit_done_flag && txd_o)
    else $error("transmit done not set with stop bit on line");
  a_rx_flag_guard: assert property (uart_mode && !$past(wr_control)
    && $rose(receive_done_flag) |-> $past(rx_bit_valid) && $past(rx_bit_value))
    else $error("receive flag raised without a good stop bit");
  a_multiproc_eight: assert property (rx_load && mode == MODE_UART8 && multiproc_enable
    |=> receive_ninth_bit)
    else $error("multiprocessor frame accepted without stop bit");
  a_multiproc_nine: assert property (rx_load && nine_bit && multiproc_enable
    |=> receive_ninth_bit && receive_done_flag)
    else $error("multiprocessor frame accepted with ninth bit zero");
  a_rx_disable_idle: assert property (!rx_enable |=> rx_state == RX_IDLE)
    else $error("receiver active while disabled");
  a_ninth_loaded: assert property (wr_data && nine_bit
    |=> tx_shift[8] == $past(transmit_ninth_bit))
    else $error("ninth bit not loaded from control field");
  a_stop_loaded: assert property (wr_data && mode == MODE_UART8 |=> tx_shift[8])
    else $error("stop bit missing from ninth position");
  a_buffer_load: assert property (rx_load |=> rx_buffer == $past(next_rx_byte))
    else $error("receive buffer not updated");
  a_shift_clock_half: assert property (m0_state != M0_IDLE && m0_phase == 4'h0 && !wr_data
    && !uart_mode |=> !txd_o [*5] ##1 txd_o)
    else $error("shift clock low phase wrong length");
  a_shift_drive: assert property (m0_state == M0_TX
    |-> rxd_oe_o && (!txd_o == (m0_phase < SHIFT_HALF)))
    else $error("shift transmit pin drive wrong");
  a_fixed_rate: assert property (fixed_rate && !rate_double_i && tx_os_tick && !wr_control
    |=> !tx_os_tick)
    else $error("fixed rate oversample too fast");

  c_uart_tx_done: cover property (uart_mode && tx_done_set);
  c_uart_rx_load: cover property (uart_accept);
  c_shift_tx_done: cover property (m0_done && m0_state == M0_TX);
  c_shift_rx_done: cover property (m0_done && m0_state == M0_RX);
endmodule
`default_nettype wire

// ===== common/serial_pkg.sv
// Constants, field layout and mode encodings for the four-mode serial port.
// Assumes a single core clock; timer overflow strobes arrive as one-cycle pulses.
package serial_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register addresses and reset values
  localparam logic [7:0] CONTROL_STATUS_ADDR = 8'h98;
  localparam logic [7:0] DATA_BUFFER_ADDR = 8'h99;
  localparam logic [7:0] CONTROL_STATUS_RESET = 8'h00;
  localparam logic [7:0] DATA_BUFFER_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions inside serial_control_status
  localparam int MODE_SELECT_HI_BIT = 7;
  localparam int MODE_SELECT_LO_BIT = 6;
  localparam int MULTIPROC_ENABLE_BIT = 5;
  localparam int RX_ENABLE_BIT = 4;
  localparam int TRANSMIT_NINTH_BIT = 3;
  localparam int RECEIVE_NINTH_BIT = 2;
  localparam int TRANSMIT_DONE_BIT = 1;
  localparam int RECEIVE_DONE_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Operating modes
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_UART9_FIXED = 2'b10,
    MODE_UART9_VAR = 2'b11
  } serial_mode_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing counts, in core clocks or rate strobes
  localparam logic [3:0] SHIFT_DIVIDE = 4'hC;
  localparam logic [3:0] SHIFT_HALF = 4'h6;
  localparam logic [4:0] OVERSAMPLE = 5'h10;
  localparam logic [4:0] PRESCALE_NORMAL = 5'h02;
  localparam logic [4:0] PRESCALE_DOUBLE = 5'h01;
  localparam logic [4:0] TIMER2_PRESCALE = 5'h01;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [2:0] SHIFT_LAST_BIT = 3'h7;

endpackage

// ===== src/strobe_divider.sv
// Divides a one-cycle strobe by a run-time count and emits one tick per period.
// Assumes strobe_i is synchronous to ref_clk_i and divide_i is at least one.
`timescale 1ns/1ps
`default_nettype none
module strobe_divider (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clear_i,
  input wire logic strobe_i,
  input wire logic [4:0] divide_i,
  output logic tick_o
);
  import serial_pkg::*;

  logic [4:0] count;
  logic at_end;

  // Tick on the strobe that closes a period
  assign at_end = (count >= divide_i - 5'h01);
  assign tick_o = strobe_i && at_end;

  // Period counter; clear keeps the phase aligned after a mode change
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || clear_i) begin
      count <= 5'h00;
    end else if (strobe_i) begin
      count <= at_end ? 5'h00 : count + 5'h01;
    end
  end
endmodule
`default_nettype wire

// ===== src/bit_sampler.sv
// Samples the receive line three times around mid-bit and votes on the value.
// Assumes os_tick_i runs at sixteen times the bit rate and restart_i marks a start edge.
`timescale 1ns/1ps
`default_nettype none
module bit_sampler (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic restart_i,
  input wire logic os_tick_i,
  input wire logic line_i,
  output logic bit_valid_o,
  output logic bit_value_o
);
  import serial_pkg::*;

  logic [3:0] os_count;
  logic [1:0] votes;

  // Majority of three samples rejects a single-tick glitch
  assign bit_valid_o = os_tick_i && (os_count == SAMPLE_LAST);
  assign bit_value_o = (votes[0] & votes[1]) | (votes[0] & line_i) | (votes[1] & line_i);

  // Position within the bit, restarted on the falling start edge
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || restart_i) begin
      os_count <= 4'h0;
    end else if (os_tick_i) begin
      os_count <= os_count + 4'h1;
    end
  end

  // Early samples kept for the vote
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      votes <= 2'b11;
    end else if (os_tick_i && os_count >= SAMPLE_FIRST && os_count < SAMPLE_LAST) begin
      votes <= {votes[0], line_i};
    end
  end
endmodule
`default_nettype wire

// ===== test/serial_node.sv
// Remote serial node: sends frames on the receive pin, decodes frames on txd.
// Assumes the bench sets nine and shift to match the port's current mode.
`timescale 1ns/1ps
`default_nettype none
module serial_node #(parameter int BIT_CLKS = 16) (
  input wire logic ref_clk_i,
  input wire logic txd_i,
  output logic line_o
);
  int nine = 0;
  int shift = 0;
  logic [10:0] v;
  logic [10:0] rx_q[$];
  initial line_o = 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  // One idle bit, start, data LSB first, optional ninth, then stop
  task automatic send(input logic [8:0] d, input logic stop);
    logic [11:0] f;
    f = nine ? {stop, d, 2'b01} : {1'b1, stop, d[7:0], 2'b01};
    for (int i = 0; i < 11 + nine; i++) begin
      line_o = f[i];
      repeat (BIT_CLKS) @(posedge ref_clk_i);
      #1;
    end
  endtask
  // Shift mode: new bit after each falling clock; line flips once released
  task automatic shift_in(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_i);
      #1;
      line_o = d[i];
    end
    @(posedge txd_i);
    #1;
    line_o = ~d[7];
  endtask
  // Sample each bit at its centre; unused top bit reads as one
  always @(negedge txd_i) begin
    if (shift == 0) begin
      v = '1;
      repeat (BIT_CLKS / 2) @(posedge ref_clk_i);
      for (int i = 0; i < 10 + nine; i++) begin
        v[i] = txd_i;
        if (i < 9 + nine) repeat (BIT_CLKS) @(posedge ref_clk_i);
      end
      rx_q.push_back(v);
    end
  end
endmodule
`default_nettype wire

// ===== test/four_mode_serial_port_tb.sv
// Self-checking bench for the four-mode serial port facing a remote node.
// Assumes timer strobes every clock, so every UART mode runs 16 clocks a bit while doubling is set.
`timescale 1ns/1ps
`default_nettype none
module four_mode_serial_port_tb;
  import serial_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic tx_sel = 1'b0;
  logic dbl = 1'b1;
  logic rxd_o, rxd_oe_o, txd_o, line, tb8;
  logic [7:0] d;
  logic [10:0] got, fr;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  int model_q[$];
  time t0;
  // The pin is driven by the port in shift transmit, else by the node
  wire logic rxd = rxd_oe_o ? rxd_o : line;
  four_mode_serial_port DUT (.ref_clk_i, .reset_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
    .sfr_rd_i, .sfr_rdata_o, .rate_double_i(dbl), .rx_clock_select_i(~tx_sel),
    .tx_clock_select_i(tx_sel), .timer1_overflow_i(1'b1), .timer2_overflow_i(1'b1),
    .rxd_i(rxd), .rxd_o, .rxd_oe_o, .txd_o);
  serial_node #(.BIT_CLKS(16)) node (.ref_clk_i, .txd_i(txd_o), .line_o(line));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  // Cut a hang short well beyond the expected run length
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  // Strobes are lowered and a clock passes before the next access
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr_i = a;
    sfr_wdata_i = v;
    sfr_wr_i = 1'b1;
    tick(1);
    sfr_wr_i = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    tick(1);
    sfr_rd_i = 1'b0;
    got = {3'b000, sfr_rdata_o};
    tick(1);
  endtask
  task automatic ctl(input logic [1:0] m, input logic mp, ren, t8);
    wr(CONTROL_STATUS_ADDR, {m, mp, ren, t8, 3'b000});
  endtask
  // One frame from the node, then a second that must be lost if accepted
  task automatic rx_case(input logic [1:0] m, input logic mp, ren, input logic [8:0] v,
                         input logic stop);
    logic ok;
    logic n;
    node.nine = m[1];
    ctl(m, mp, ren, 1'b0);
    node.send(v, stop);
    n = m[1] ? v[8] : stop;
    ok = ren && stop && (!mp || n);
    rd(CONTROL_STATUS_ADDR);
    chk(got, {3'b000, m, mp, ren, 1'b0, ok & n, 1'b0, ok});
    if (ok) begin
      model_q.push_back(int'(v[7:0]));
      node.send(~v, 1'b1);
      rd(DATA_BUFFER_ADDR);
      chk(got, 11'(model_q.pop_front()));
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(13648));
    tick(4);
    reset_i = 1'b0;
    rd(CONTROL_STATUS_ADDR);
    chk(got, {3'b000, CONTROL_STATUS_RESET});
    rd(8'h42);
    chk(got, {3'b000, UNMAPPED_READ});
    $display("test registers done");
    // Shift mode transmit: data on the receive pin, clock on txd
    node.shift = 1;
    d = 8'($urandom);
    wr(DATA_BUFFER_ADDR, d);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_o);
      fr[i] = rxd;
      if (i == 0) t0 = $time;
    end
    chk(11'(($time - t0) / 25), 11'd84);
    chk({3'b000, fr[7:0]}, {3'b000, d});
    tick(20);
    rd(CONTROL_STATUS_ADDR);
    chk(got, 11'h002);
    // Shift mode receive begins as soon as enabled with the flag clear
    d = 8'($urandom);
    fork
      node.shift_in(d);
    join_none
    ctl(2'b00, 1'b0, 1'b1, 1'b0);
    tick(110);
    rd(CONTROL_STATUS_ADDR);
    chk(got, 11'h011);
    rd(DATA_BUFFER_ADDR);
    chk(got, {3'b000, d});
    ctl(2'b00, 1'b0, 1'b0, 1'b0);
    node.shift = 0;
    $display("test shift mode done");
    // UART transmit in each mode, tx rate from timer 1, the core clock or timer 2
    for (int m = 1; m < 4; m++) begin
      tx_sel = m[1];
      d = 8'($urandom);
      tb8 = 1'($urandom);
      node.nine = m / 2;
      ctl(2'(m), 1'b0, 1'b0, tb8);
      wr(DATA_BUFFER_ADDR, d);
      tick(240);
      fr = node.rx_q.size() > 0 ? node.rx_q.pop_front() : 'x;
      chk(fr, {1'b1, m > 1 ? tb8 : 1'b1, d, 1'b0});
      rd(CONTROL_STATUS_ADDR);
      chk(got, {3'b000, 2'(m), 2'b00, tb8, 3'b010});
    end
    $display("test uart transmit done");
    // UART receive: plain, multiprocessor reject and accept, disabled
    for (int m = 1; m < 4; m++) begin
      tx_sel = m[1];
      rx_case(2'(m), 1'b0, 1'b1, 9'($urandom), 1'b1);
      rx_case(2'(m), 1'b1, 1'b1, {1'b0, 8'($urandom)}, m[1]);
      rx_case(2'(m), 1'b1, 1'b1, {1'b1, 8'($urandom)}, 1'b1);
      rx_case(2'(m), 1'b0, 1'b0, 9'($urandom), 1'b1);
    end
    $display("test uart receive done");
    // Fixed rate without doubling: the start bit lasts 32 clocks
    dbl = 1'b0;
    ctl(2'b10, 1'b0, 1'b0, 1'b1);
    wr(DATA_BUFFER_ADDR, 8'hFF);
    @(negedge txd_o);
    t0 = $time;
    @(posedge txd_o);
    chk(11'(($time - t0) / 25), 11'd32);
    $display("test fixed rate done");
    summarize();
  end
  task automatic summarize();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
endmodule
`default_nettype wire
